// *** pkg/lcv_params.svh ***
// Offsets, field positions, reset values and rates of the clock and
// violation control bank.
// Assumes an 8-bit register port whose addresses match these offsets.
`ifndef LCV_PARAMS_SVH
`define LCV_PARAMS_SVH
`define LCV_OFS_GLOBAL 8'h07
`define LCV_OFS_TESTER 8'h10
`define LCV_OFS_INSERT 8'h11
`define LCV_OFS_LVDS 8'h12
`define LCV_OFS_RCKI 8'h13
`define LCV_OFS_TCKI 8'h14
`define LCV_OFS_CLKCTL 8'h15
`define LCV_OFS_KILL 8'h16
`define LCV_OFS_ISC 8'h1e
`define LCV_OFS_MCLK 8'h26
`define LCV_RST_VAL 8'h00
`define LCV_MASK_MCLK 8'h7f
`define LCV_MASK_GLOBAL 8'h07
`define LCV_MASK_TESTER 8'he1
`define LCV_MASK_ISC 8'h03
`define LCV_MCLK_PLL_EN 0
`define LCV_MCLK_FAMILY 1
`define LCV_MCLK_PERIOD_LSB 2
`define LCV_MCLK_AUX_EN 4
`define LCV_MCLK_REF_EN 5
`define LCV_MCLK_REF_SRC 6
`define LCV_GLB_HITLESS 0
`define LCV_GLB_JBW_LSB 1
`define LCV_TST_EN 0
`define LCV_TST_LANE_LSB 5
`define LCV_CKC_AUX_LSB 0
`define LCV_CKC_REF_RATE 4
`define LCV_CKC_LANE_LSB 5
`define LCV_ISC_COW 0
`define LCV_ISC_PIN_MODE 1
`define LCV_WINDOW_CYC 2'h3
`define LCV_KHZ_E1 16'h0800
`define LCV_KHZ_T1 16'h0608
`define LCV_KHZ_T1_GAP 16'h0600
`define LCV_KHZ_LOW 16'h0020
`define LCV_MHZ_JBW 13'h0271
`define LCV_CORE_KHZ 32'h000186a0
`define LCV_INC_PER_KHZ 32'h0000a7c6
`endif

// *** pkg/lcv_pkg.sv ***
// Types shared by the clock and violation control bank.
// Assumes lcv_params.svh supplies the numeric constants.
package lcv_pkg;
   // Per-channel line events, one bit per channel, one-cycle pulses.
   typedef struct packed {
      logic [7:0] bpv;
      logic [7:0] cv;
      logic [7:0] exz;
   } lcv_line_ev_t;
   // Per-channel decoder setup held in the neighbouring registers.
   typedef struct packed {
      logic [7:0] exz_det_en;
      logic [7:0] cv_det_dis;
      logic [7:0] hdb3;
      logic [7:0] dual_rail;
   } lcv_line_cfg_t;
   // Whole module state; every output is a field of it.
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] pin;
      logic rd_act;
      logic wr_act;
      logic [7:0] mclk_sel;
      logic [7:0] glb;
      logic [7:0] tst_ctl;
      logic [7:0] ins;
      logic [7:0] lvds;
      logic [7:0] rcki;
      logic [7:0] tcki;
      logic [7:0] clk_ctl;
      logic [7:0] kill;
      logic [7:0] isc;
      logic [7:0][1:0] win;
      logic [31:0] ref_acc;
      logic [31:0] aux_acc;
      logic [7:0] dout;
      logic dout_oe_n;
      logic [7:0] inject;
      logic pll_bypass;
      logic fixed_t1;
      logic [15:0] mclk_khz;
      logic [12:0] jbw_mhz;
      logic imp_off;
      logic [7:0] tester;
      logic pll_rec;
      logic [2:0] pll_lane;
      logic ref_pin;
      logic aux_pin;
      logic aux_oe_n;
      logic [7:0] rx_fall;
      logic [7:0] tx_inv;
      logic [7:0] rclk_low;
      logic [7:0] rclk_mclk;
      logic irq_n;
      logic irq_oe_n;
   } lcv_state_t;
endpackage

// *** core/lcv_ctrl.sv ***
// Global clock, tester-lane and line-violation control bank of an
// eight-channel line interface, reached through its 8-bit register port.
// Assumes address and write data are stable while a strobe is low and
// that line events and loss flags come from logic on CORE_CLK_IN.
//
// Function
// R1 - Reference pin carries the rate clock when enabled, else receive loss; enabled with the PLL off, it stays low.
// R2 - Auxiliary clock pin drives when enabled, else released to tristate.
// R3 - PLL off: master clock used directly, its rate fixes T1 or E1.
// R4 - PLL on, family set: period codes mean 1.544 to 12.352 MHz.
// R5 - PLL on, family clear: period codes mean 2.048 to 16.384 MHz.
// R6 - Jitter bandwidth field picks 0.625, 1.25, 2.5 or 5.0 Hz corner.
// R7 - Hitless bit with output-enable pin low turns off receiver matching.
// R8 - Tester enabled works on exactly one lane; lane select ignored otherwise.
// R9 - Rising insert bit injects exactly one bipolar violation on that channel.
// R10 - Violation status latches on bipolar, code or excess-zero event.
// R11 - Status clears on read, or only on write when clear-on-write set.
// R12 - Only first violation in a three-cycle window latches, reads notwithstanding.
// R13 - Excess zeros need enable; code violations need HDB3; dual rail bipolar only.
// R14 - Receive invert bit or high edge pin selects falling-edge receive data.
// R15 - System aligns transmit data to rising edge when transmit invert set.
// R16 - PLL lane field 000 to 111 picks recovered clock of channels 1-8.
// R17 - Loss on the PLL reference lane falls back to master clock meanwhile.
// R18 - Reference clock runs 2.048 MHz when rate bit set, else 1.544 MHz; it does not run with the PLL off.
// R19 - Four-bit auxiliary code picks one of four doubling rate families.
// R20 - On loss, kill bit holds recovered clock low, else master clock used.
// R21 - Interrupt pin drives low when active; idle is tristate or high.
// R22 - With clear-on-write, a status bit clears only on a written one.
// R23 - PLL source bit picks master clock at 0, recovered lane at 1.
`timescale 1ns/1ns
`include "lcv_params.svh"
module lcv_ctrl (
   // Clock and reset.
   input wire logic CORE_CLK_IN,
   input wire logic SRST_IN,
   // Register port pins.
   input wire logic CS_N_IN,
   input wire logic RD_N_IN,
   input wire logic WR_N_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE_N_OUT,
   // Board pins.
   input wire logic OUT_EN_PIN_IN,
   input wire logic RX_EDGE_SELECT_PIN_IN,
   input wire logic MCLK_IS_T1_PIN_IN,
   // Line side status from the channels.
   input wire lcv_pkg::lcv_line_ev_t LINE_EV_IN,
   input wire lcv_pkg::lcv_line_cfg_t LINE_CFG_IN,
   input wire logic [7:0] RX_LOSS_IN,
   input wire logic IRQ_SRC_IN,
   // Clock plan controls.
   output logic PLL_BYPASS_OUT,
   output logic FIXED_T1_OUT,
   output logic [15:0] MCLK_KHZ_OUT,
   output logic [12:0] JITTER_BW_MHZ_OUT,
   output logic PLL_REF_RECOVERED_OUT,
   output logic [2:0] PLL_REF_LANE_OUT,
   output logic REF_CLOCK_OUT,
   output logic AUX_CLOCK_OUT,
   output logic AUX_CLOCK_OE_N_OUT,
   // Receiver impedance switch and per-channel controls.
   output logic RX_IMPEDANCE_OFF_OUT,
   output logic [7:0] TESTER_LANE_EN_OUT,
   output logic [7:0] INJECT_BPV_OUT,
   output logic [7:0] RX_FALL_EDGE_OUT,
   output logic [7:0] TX_CLOCK_INVERT_OUT,
   output logic [7:0] RCLK_HOLD_LOW_OUT,
   output logic [7:0] RCLK_USE_MCLK_OUT,
   // Interrupt pin.
   output logic IRQ_N_OUT,
   output logic IRQ_OE_N_OUT
);
   import lcv_pkg::*;

   localparam int P_T1 = 0;
   localparam int P_EDGE = 1;
   localparam int P_OE = 2;
   localparam int P_WR = 3;
   localparam int P_RD = 4;
   localparam int P_CS = 5;

   lcv_state_t cur_ff;
   lcv_state_t nxt_st;
   logic [7:0] ev;
   logic [7:0] clr;
   logic rd_now;
   logic wr_now;
   logic rd_go;
   logic wr_go;

   // Phase step of a numeric oscillator running from the core clock.
   function automatic logic [31:0] nco_inc(input logic [15:0] khz);
      nco_inc = 32'({16'h0000, khz} * `LCV_INC_PER_KHZ);
   endfunction

   // Auxiliary rate in kHz: a base per family, doubled per step.
   function automatic logic [15:0] aux_khz(input logic [3:0] code);
      logic [15:0] base;
      base = `LCV_KHZ_LOW;
      unique case (code[3:2])
         2'h0: base = `LCV_KHZ_E1;
         2'h1: base = `LCV_KHZ_T1;
         2'h2: base = `LCV_KHZ_T1_GAP;
         2'h3: base = `LCV_KHZ_LOW;
      endcase
      aux_khz = 16'(base << code[1:0]);
   endfunction

   // Register read multiplexer; unmapped offsets read as zero.
   function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                         input lcv_state_t s);
      rd_mux = 8'h00;
      unique case (a)
         `LCV_OFS_MCLK: rd_mux = s.mclk_sel;
         `LCV_OFS_GLOBAL: rd_mux = s.glb;
         `LCV_OFS_TESTER: rd_mux = s.tst_ctl;
         `LCV_OFS_INSERT: rd_mux = s.ins;
         `LCV_OFS_LVDS: rd_mux = s.lvds;
         `LCV_OFS_RCKI: rd_mux = s.rcki;
         `LCV_OFS_TCKI: rd_mux = s.tcki;
         `LCV_OFS_CLKCTL: rd_mux = s.clk_ctl;
         `LCV_OFS_KILL: rd_mux = s.kill;
         `LCV_OFS_ISC: rd_mux = s.isc;
         default: rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      nxt_st = cur_ff;
      // Three-stage pin synchroniser; a level counts once stages 2 and 3 agree.
      nxt_st.s1 = {CS_N_IN, RD_N_IN, WR_N_IN, OUT_EN_PIN_IN,
                   RX_EDGE_SELECT_PIN_IN, MCLK_IS_T1_PIN_IN};
      nxt_st.s2 = cur_ff.s1;
      nxt_st.s3 = cur_ff.s2;
      for (int i = 0; i < 6; i++) begin
         if (cur_ff.s2[i] == cur_ff.s3[i]) begin
            nxt_st.pin[i] = cur_ff.s3[i];
         end
      end
      rd_now = !cur_ff.pin[P_CS] && !cur_ff.pin[P_RD];
      wr_now = !cur_ff.pin[P_CS] && !cur_ff.pin[P_WR] && cur_ff.pin[P_RD];
      nxt_st.rd_act = rd_now;
      nxt_st.wr_act = wr_now;
      rd_go = rd_now && !cur_ff.rd_act;
      wr_go = wr_now && !cur_ff.wr_act;
      clr = 8'h00;
      nxt_st.inject = 8'h00;
      // Data is captured once per strobe and held until the strobe ends.
      nxt_st.dout_oe_n = !rd_now;
      if (rd_go) begin
         nxt_st.dout = rd_mux(ADDR_IN, cur_ff);
         if (ADDR_IN == `LCV_OFS_LVDS && !cur_ff.isc[`LCV_ISC_COW]) begin
            clr = cur_ff.lvds; // [R11]
         end
      end
      if (wr_go) begin
         unique case (ADDR_IN)
            `LCV_OFS_MCLK: nxt_st.mclk_sel = DATA_IN & `LCV_MASK_MCLK;
            `LCV_OFS_GLOBAL: nxt_st.glb = DATA_IN & `LCV_MASK_GLOBAL;
            `LCV_OFS_TESTER: nxt_st.tst_ctl = DATA_IN & `LCV_MASK_TESTER;
            `LCV_OFS_INSERT: begin
               nxt_st.ins = DATA_IN;
               nxt_st.inject = DATA_IN & ~cur_ff.ins; // [R9]
            end
            `LCV_OFS_LVDS: begin
               if (cur_ff.isc[`LCV_ISC_COW]) begin
                  clr = DATA_IN; // [R11] [R22]
               end
            end
            `LCV_OFS_RCKI: nxt_st.rcki = DATA_IN;
            `LCV_OFS_TCKI: nxt_st.tcki = DATA_IN;
            `LCV_OFS_CLKCTL: nxt_st.clk_ctl = DATA_IN;
            `LCV_OFS_KILL: nxt_st.kill = DATA_IN;
            `LCV_OFS_ISC: nxt_st.isc = DATA_IN & `LCV_MASK_ISC;
            default: nxt_st.isc = cur_ff.isc;
         endcase
      end
      // Qualified line events per channel.
      ev = LINE_EV_IN.bpv | (~LINE_CFG_IN.dual_rail & // [R13]
           ((LINE_EV_IN.exz & LINE_CFG_IN.exz_det_en) |
            (LINE_EV_IN.cv & LINE_CFG_IN.hdb3 & ~LINE_CFG_IN.cv_det_dis)));
      for (int c = 0; c < 8; c++) begin
         // The window runs on its own, so a read cannot reopen it early.
         if (ev[c] && cur_ff.win[c] == 2'h0) begin
            nxt_st.win[c] = `LCV_WINDOW_CYC; // [R12]
            nxt_st.lvds[c] = 1'b1; // [R10]
         end else begin
            if (cur_ff.win[c] != 2'h0) begin
               nxt_st.win[c] = cur_ff.win[c] - 2'h1; // [R12]
            end
            // An event that opens a window beats a clear arriving in the same cycle.
            nxt_st.lvds[c] = cur_ff.lvds[c] && !clr[c]; // [R11]
         end
      end
      // Master clock plan.
      nxt_st.pll_bypass = !cur_ff.mclk_sel[`LCV_MCLK_PLL_EN]; // [R3]
      nxt_st.fixed_t1 = !cur_ff.mclk_sel[`LCV_MCLK_PLL_EN] &&
                        cur_ff.pin[P_T1]; // [R3]
      if (cur_ff.mclk_sel[`LCV_MCLK_PLL_EN]) begin
         nxt_st.mclk_khz = cur_ff.mclk_sel[`LCV_MCLK_FAMILY] ? // [R4] [R5]
            16'(`LCV_KHZ_T1 << cur_ff.mclk_sel[`LCV_MCLK_PERIOD_LSB +: 2]) :
            16'(`LCV_KHZ_E1 << cur_ff.mclk_sel[`LCV_MCLK_PERIOD_LSB +: 2]);
      end else begin
         nxt_st.mclk_khz = 16'h0000; // [R3]
      end
      nxt_st.jbw_mhz = 13'(`LCV_MHZ_JBW <<
                           cur_ff.glb[`LCV_GLB_JBW_LSB +: 2]); // [R6]
      nxt_st.imp_off = cur_ff.glb[`LCV_GLB_HITLESS] &&
                       !cur_ff.pin[P_OE]; // [R7]
      nxt_st.tester = cur_ff.tst_ctl[`LCV_TST_EN] ? // [R8]
         8'(8'h01 << cur_ff.tst_ctl[`LCV_TST_LANE_LSB +: 3]) : 8'h00;
      // PLL reference; lane code n selects channel n+1.
      nxt_st.pll_lane = cur_ff.clk_ctl[`LCV_CKC_LANE_LSB +: 3]; // [R16]
      nxt_st.pll_rec = cur_ff.mclk_sel[`LCV_MCLK_REF_SRC] && // [R23]
         !RX_LOSS_IN[cur_ff.clk_ctl[`LCV_CKC_LANE_LSB +: 3]]; // [R17]
      // The oscillators only run with the PLL on; without it the aux pin and an enabled reference pin idle low.
      if (cur_ff.mclk_sel[`LCV_MCLK_PLL_EN]) begin
         nxt_st.ref_acc = cur_ff.ref_acc + nco_inc( // [R18]
            cur_ff.clk_ctl[`LCV_CKC_REF_RATE] ? `LCV_KHZ_E1 : `LCV_KHZ_T1);
         nxt_st.aux_acc = cur_ff.aux_acc + // [R19]
            nco_inc(aux_khz(cur_ff.clk_ctl[`LCV_CKC_AUX_LSB +: 4]));
      end else begin
         nxt_st.ref_acc = 32'h00000000;
         nxt_st.aux_acc = 32'h00000000;
      end
      nxt_st.ref_pin = cur_ff.mclk_sel[`LCV_MCLK_REF_EN] ?
                       cur_ff.ref_acc[31] : (|RX_LOSS_IN); // [R1]
      nxt_st.aux_pin = cur_ff.aux_acc[31]; // [R2]
      nxt_st.aux_oe_n = !cur_ff.mclk_sel[`LCV_MCLK_AUX_EN]; // [R2]
      // Receive and transmit clock polarity.
      nxt_st.rx_fall = cur_ff.rcki | {8{cur_ff.pin[P_EDGE]}}; // [R14]
      nxt_st.tx_inv = cur_ff.tcki; // [R15]
      nxt_st.rclk_low = RX_LOSS_IN & cur_ff.kill; // [R20]
      nxt_st.rclk_mclk = RX_LOSS_IN & ~cur_ff.kill; // [R20]
      // Interrupt pin: low when active, idle level set by the pin mode.
      if (IRQ_SRC_IN || (|cur_ff.lvds)) begin
         nxt_st.irq_n = 1'b0; // [R21]
         nxt_st.irq_oe_n = 1'b0;
      end else begin
         nxt_st.irq_n = 1'b1;
         nxt_st.irq_oe_n = !cur_ff.isc[`LCV_ISC_PIN_MODE]; // [R21]
      end
      if (SRST_IN) begin
         nxt_st = '0;
         // Strobes and output enable idle high, edge and rate pins low.
         nxt_st.s1 = 6'h3c;
         nxt_st.s2 = 6'h3c;
         nxt_st.s3 = 6'h3c;
         nxt_st.pin = 6'h3c;
         nxt_st.mclk_sel = `LCV_RST_VAL;
         nxt_st.dout_oe_n = 1'b1;
         nxt_st.pll_bypass = 1'b1;
         nxt_st.aux_oe_n = 1'b1;
         nxt_st.irq_n = 1'b1;
         nxt_st.irq_oe_n = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      cur_ff <= nxt_st;
   end

   assign DATA_OUT = cur_ff.dout;
   assign DATA_OE_N_OUT = cur_ff.dout_oe_n;
   assign PLL_BYPASS_OUT = cur_ff.pll_bypass;
   assign FIXED_T1_OUT = cur_ff.fixed_t1;
   assign MCLK_KHZ_OUT = cur_ff.mclk_khz;
   assign JITTER_BW_MHZ_OUT = cur_ff.jbw_mhz;
   assign PLL_REF_RECOVERED_OUT = cur_ff.pll_rec;
   assign PLL_REF_LANE_OUT = cur_ff.pll_lane;
   assign REF_CLOCK_OUT = cur_ff.ref_pin;
   assign AUX_CLOCK_OUT = cur_ff.aux_pin;
   assign AUX_CLOCK_OE_N_OUT = cur_ff.aux_oe_n;
   assign RX_IMPEDANCE_OFF_OUT = cur_ff.imp_off;
   assign TESTER_LANE_EN_OUT = cur_ff.tester;
   assign INJECT_BPV_OUT = cur_ff.inject;
   assign RX_FALL_EDGE_OUT = cur_ff.rx_fall;
   assign TX_CLOCK_INVERT_OUT = cur_ff.tx_inv;
   assign RCLK_HOLD_LOW_OUT = cur_ff.rclk_low;
   assign RCLK_USE_MCLK_OUT = cur_ff.rclk_mclk;
   assign IRQ_N_OUT = cur_ff.irq_n;
   assign IRQ_OE_N_OUT = cur_ff.irq_oe_n;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (SRST_IN);

   property p_lv_latch;
      ev[0] && cur_ff.win[0] == 2'h0 |=> LINE_EV_IN.bpv[0] ||
         (cur_ff.lvds[0] && cur_ff.win[0] == 2'h3);
   endproperty
   a_lv_latch: assert property (p_lv_latch) // [R10]
      else $error("violation status did not latch");

   property p_lv_window;
      cur_ff.win[0] != 2'h0 && !cur_ff.lvds[0] |=> !cur_ff.lvds[0];
   endproperty
   a_lv_window: assert property (p_lv_window) // [R12]
      else $error("second violation latched inside window");

   property p_lv_rd_clear;
      rd_go && ADDR_IN == `LCV_OFS_LVDS && !cur_ff.isc[`LCV_ISC_COW] &&
         ev == 8'h00 |=> cur_ff.lvds == 8'h00;
   endproperty
   a_lv_rd_clear: assert property (p_lv_rd_clear) // [R11]
      else $error("status not cleared by read");

   property p_lv_cwe_hold;
      cur_ff.isc[`LCV_ISC_COW] && !wr_go && cur_ff.lvds[0] |=>
         cur_ff.lvds[0];
   endproperty
   a_lv_cwe_hold: assert property (p_lv_cwe_hold) // [R22]
      else $error("status cleared without a write");

   property p_inject_pulse;
      INJECT_BPV_OUT[0] |=> !INJECT_BPV_OUT[0] && cur_ff.ins[0];
   endproperty
   a_inject_pulse: assert property (p_inject_pulse) // [R9]
      else $error("violation insert not a single pulse");

   property p_tester_lane;
      $onehot0(TESTER_LANE_EN_OUT) &&
         (!$past(cur_ff.tst_ctl[`LCV_TST_EN]) -> TESTER_LANE_EN_OUT == 8'h00);
   endproperty
   a_tester_lane: assert property (p_tester_lane) // [R8]
      else $error("tester lane selection wrong");

   property p_pll_fallback;
      RX_LOSS_IN[cur_ff.clk_ctl[`LCV_CKC_LANE_LSB +: 3]] |=>
         !PLL_REF_RECOVERED_OUT;
   endproperty
   a_pll_fallback: assert property (p_pll_fallback) // [R17]
      else $error("PLL kept a lost recovered clock");

   property p_irq_idle;
      !IRQ_SRC_IN && cur_ff.lvds == 8'h00 && !cur_ff.isc[`LCV_ISC_PIN_MODE]
         |=> IRQ_OE_N_OUT;
   endproperty
   a_irq_idle: assert property (p_irq_idle) // [R21]
      else $error("interrupt pin driven while idle");

   property p_edge_pin;
      cur_ff.pin[P_EDGE] |=> RX_FALL_EDGE_OUT == 8'hff;
   endproperty
   a_edge_pin: assert property (p_edge_pin) // [R14]
      else $error("edge pin did not force falling edge");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the clock and violation control bank.
// Assumes the bank's register port is driven only through wr and rd here.
`timescale 1ns/1ns
`include "lcv_params.svh"
module tb_top;
   import lcv_pkg::*;
   logic clk = 0, srst = 1, cs_n = 1, rd_n = 1, wr_n = 1;
   logic oe_pin = 1, edge_pin = 0, t1_pin = 0, irq_src = 0;
   logic [7:0] addr = 0, din = 0, loss = 0, dout;
   lcv_line_ev_t ev = '0;
   lcv_line_cfg_t cfg = '0;
   logic doe_n, bypass, fix_t1, rec, refc, auxc, aux_oe_n, imp, irq_n;
   logic irq_oe_n;
   logic [15:0] khz;
   logic [12:0] jbw;
   logic [2:0] lane;
   logic [7:0] tst, inj, fall, tinv, hold, usem, v;
   int failures = 0, n_compared = 0, cycles = 0, inj_n = 0, ref_n = 0;
   int n0, n1, aux_n = 0;
   logic ref_q = 0, aux_q = 0;

   lcv_ctrl i_dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .CS_N_IN(cs_n),
      .RD_N_IN(rd_n), .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(din),
      .DATA_OUT(dout), .DATA_OE_N_OUT(doe_n), .OUT_EN_PIN_IN(oe_pin),
      .RX_EDGE_SELECT_PIN_IN(edge_pin), .MCLK_IS_T1_PIN_IN(t1_pin),
      .LINE_EV_IN(ev), .LINE_CFG_IN(cfg), .RX_LOSS_IN(loss),
      .IRQ_SRC_IN(irq_src), .PLL_BYPASS_OUT(bypass), .FIXED_T1_OUT(fix_t1),
      .MCLK_KHZ_OUT(khz), .JITTER_BW_MHZ_OUT(jbw),
      .PLL_REF_RECOVERED_OUT(rec), .PLL_REF_LANE_OUT(lane),
      .REF_CLOCK_OUT(refc), .AUX_CLOCK_OUT(auxc),
      .AUX_CLOCK_OE_N_OUT(aux_oe_n), .RX_IMPEDANCE_OFF_OUT(imp),
      .TESTER_LANE_EN_OUT(tst), .INJECT_BPV_OUT(inj),
      .RX_FALL_EDGE_OUT(fall), .TX_CLOCK_INVERT_OUT(tinv),
      .RCLK_HOLD_LOW_OUT(hold), .RCLK_USE_MCLK_OUT(usem),
      .IRQ_N_OUT(irq_n), .IRQ_OE_N_OUT(irq_oe_n));

   always #5 clk = ~clk;

   // Pulses and clock edges are counted here so no single cycle is missed.
   always @(posedge clk) begin
      cycles++;
      inj_n <= inj_n + $countones(inj);
      ref_q <= refc;
      if (refc && !ref_q) begin
         ref_n <= ref_n + 1;
      end
      aux_q <= auxc;
      if (auxc && !aux_q) begin
         aux_n <= aux_n + 1;
      end
      if (cycles == 40000) begin
         failures++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Compared %0d, mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Strobes are held for seven cycles so the three-flop sync sees them.
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk);
      addr = a;
      din = d;
      cs_n = 0;
      wr_n = 0;
      repeat (7) @(negedge clk);
      wr_n = 1;
      cs_n = 1;
      repeat (7) @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      cs_n = 0;
      rd_n = 0;
      repeat (7) @(negedge clk);
      chk("read_oe", doe_n, 1'b0);
      chk("read_data", dout, exp);
      rd_n = 1;
      cs_n = 1;
      repeat (7) @(negedge clk);
      chk("idle_oe", doe_n, 1'b1);
   endtask

   task automatic pulse(input lcv_line_ev_t e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = '0;
      repeat (3) @(negedge clk);
   endtask

   task automatic t_regs();
      logic [7:0] ofs [10] = '{`LCV_OFS_MCLK, `LCV_OFS_GLOBAL,
         `LCV_OFS_TESTER, `LCV_OFS_INSERT, `LCV_OFS_RCKI, `LCV_OFS_TCKI,
         `LCV_OFS_CLKCTL, `LCV_OFS_KILL, `LCV_OFS_ISC, 8'h20};
      logic [7:0] msk [10] = '{`LCV_MASK_MCLK, `LCV_MASK_GLOBAL,
         `LCV_MASK_TESTER, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, `LCV_MASK_ISC,
         8'h00};
      rd(`LCV_OFS_LVDS, `LCV_RST_VAL);
      for (int i = 0; i < 10; i++) begin
         rd(ofs[i], `LCV_RST_VAL);
         wr(ofs[i], 8'hff);
         rd(ofs[i], msk[i]);
         wr(ofs[i], 8'h00);
      end
   endtask

   task automatic t_plan();
      chk("bypass", bypass, 1'b1);
      chk("khz_bypass", khz, 16'h0000);
      t1_pin = 1;
      repeat (8) @(negedge clk);
      chk("fixed_t1", fix_t1, 1'b1);
      for (int f = 0; f < 2; f++) begin
         for (int p = 0; p < 4; p++) begin
            wr(`LCV_OFS_MCLK, 8'(1 + f * 2 + p * 4));
            chk("khz", khz, (f ? `LCV_KHZ_T1 : `LCV_KHZ_E1) << p);
         end
      end
      for (int j = 0; j < 4; j++) begin
         wr(`LCV_OFS_GLOBAL, 8'(j * 2));
         chk("jbw", jbw, `LCV_MHZ_JBW << j);
      end
      wr(`LCV_OFS_GLOBAL, 8'h01);
      oe_pin = 0;
      repeat (8) @(negedge clk);
      chk("imp_off", imp, 1'b1);
      oe_pin = 1;
      repeat (8) @(negedge clk);
      chk("imp_on", imp, 1'b0);
      for (int l = 0; l < 8; l++) begin
         wr(`LCV_OFS_TESTER, 8'(l * 32));
         chk("tester_off", tst, 8'h00);
         wr(`LCV_OFS_TESTER, 8'(l * 32 + 1));
         chk("tester_lane", tst, 8'h01 << l);
      end
   endtask

   task automatic t_inject();
      n0 = inj_n;
      wr(`LCV_OFS_INSERT, 8'h01);
      chk("inject_one", 16'(inj_n - n0), 16'h0001);
      wr(`LCV_OFS_INSERT, 8'h01);
      chk("inject_held", 16'(inj_n - n0), 16'h0001);
      wr(`LCV_OFS_INSERT, 8'h00);
      wr(`LCV_OFS_INSERT, 8'h81);
      chk("inject_again", 16'(inj_n - n0), 16'h0003);
   endtask

   task automatic t_viol();
      pulse('{bpv: 8'h04, cv: 8'h00, exz: 8'h00});
      chk("irq_active", {irq_n, irq_oe_n}, 2'b00);
      rd(`LCV_OFS_LVDS, 8'h04);
      rd(`LCV_OFS_LVDS, 8'h00);
      chk("irq_float", irq_oe_n, 1'b1);
      pulse('{bpv: 8'h00, cv: 8'h00, exz: 8'h01});
      rd(`LCV_OFS_LVDS, 8'h00);
      cfg.exz_det_en = 8'h01;
      cfg.hdb3 = 8'hff;
      pulse('{bpv: 8'h00, cv: 8'h02, exz: 8'h01});
      rd(`LCV_OFS_LVDS, 8'h03);
      cfg.dual_rail = 8'hff;
      pulse('{bpv: 8'h00, cv: 8'h02, exz: 8'h00});
      rd(`LCV_OFS_LVDS, 8'h00);
      cfg = '0;
      cfg.hdb3 = 8'hff;
      cfg.cv_det_dis = 8'hff;
      pulse('{bpv: 8'h00, cv: 8'h02, exz: 8'h00});
      rd(`LCV_OFS_LVDS, 8'h00);
      wr(`LCV_OFS_ISC, 8'h01);
      pulse('{bpv: 8'h40, cv: 8'h00, exz: 8'h00});
      rd(`LCV_OFS_LVDS, 8'h40);
      rd(`LCV_OFS_LVDS, 8'h40);
      wr(`LCV_OFS_LVDS, 8'h00);
      rd(`LCV_OFS_LVDS, 8'h40);
      wr(`LCV_OFS_LVDS, 8'h40);
      rd(`LCV_OFS_LVDS, 8'h00);
      wr(`LCV_OFS_ISC, 8'h02);
      chk("irq_idle_high", {irq_n, irq_oe_n}, 2'b10);
      irq_src = 1;
      repeat (3) @(negedge clk);
      chk("irq_src", {irq_n, irq_oe_n}, 2'b00);
      irq_src = 0;
      wr(`LCV_OFS_ISC, 8'h00);
   endtask

   // A read clears the flag one cycle into its window; a second violation
   // two cycles later must stay unlatched.
   task automatic t_window();
      fork
         rd(`LCV_OFS_LVDS, 8'h01);
         begin
            repeat (4) @(negedge clk);
            ev.bpv = 8'h01;
            @(negedge clk);
            ev.bpv = 8'h00;
            @(negedge clk);
            ev.bpv = 8'h01;
            @(negedge clk);
            ev.bpv = 8'h00;
         end
      join
      rd(`LCV_OFS_LVDS, 8'h00);
   endtask

   task automatic t_clocks();
      wr(`LCV_OFS_RCKI, 8'h0f);
      chk("rx_fall", fall, 8'h0f);
      edge_pin = 1;
      repeat (8) @(negedge clk);
      chk("rx_fall_pin", fall, 8'hff);
      wr(`LCV_OFS_TCKI, 8'ha5);
      chk("tx_inv", tinv, 8'ha5);
      loss = 8'h10;
      wr(`LCV_OFS_MCLK, 8'h00);
      chk("ref_is_loss", refc, 1'b1);
      chk("aux_off", aux_oe_n, 1'b1);
      wr(`LCV_OFS_KILL, 8'h10);
      chk("rclk_kill", {hold, usem}, 16'h1000);
      wr(`LCV_OFS_KILL, 8'h00);
      chk("rclk_mclk", {hold, usem}, 16'h0010);
      wr(`LCV_OFS_MCLK, 8'h71);
      wr(`LCV_OFS_CLKCTL, 8'h90);
      chk("bypass_off", bypass, 1'b0);
      chk("aux_on", aux_oe_n, 1'b0);
      chk("pll_lane", lane, 3'h4);
      chk("pll_fallback", rec, 1'b0);
      loss = 8'h00;
      repeat (3) @(negedge clk);
      chk("pll_recovered", rec, 1'b1);
      for (int r = 0; r < 2; r++) begin
         n0 = ref_n;
         n1 = aux_n;
         repeat (10000) @(negedge clk);
         n0 = ref_n - n0;
         n1 = aux_n - n1;
         // Expect 204.8 or 154.4 rising edges in 100 us; NCO jitter allowed.
         chk("ref_rate", n0 >= (r ? 152 : 203) && n0 <= (r ? 157 : 207),
             1'b1);
         chk("aux_rate", n1 >= 203 && n1 <= 207, 1'b1);
         wr(`LCV_OFS_CLKCTL, 8'h80);
      end
      wr(`LCV_OFS_MCLK, 8'h31);
      chk("pll_src_mclk", rec, 1'b0);
   endtask

   initial begin
      repeat (3) @(negedge clk);
      srst = 0;
      t_regs();
      t_plan();
      t_inject();
      t_viol();
      t_window();
      t_clocks();
      test_done();
   end
endmodule
